// file: rtl/lsp_port.sv
// lsp_port.sv: serial host port, select/clock/data pins to parallel words.
// assumes host clock well below clk_i; pins are asynchronous and synchronised here.
`timescale 1ns/10ps
`include "lsp_defs.svh"
module lsp_port import lsp_pkg::*; #(
   parameter int WORD_W = `LSP_WORD_W
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic chip_select_n_i,
   input wire logic serial_clk_i,
   input wire logic serial_data_io_i,
   output logic serial_data_io_o,
   output logic serial_data_io_oe_o,
   input wire logic register_select_i,
   input wire logic read_write_i,
   input wire logic test_status_select_i,
   input wire logic [7:0] input_port_i,
   input wire logic [WORD_W-1:0] read_word_i,
   input wire logic internal_busy_flag_i,
   input wire logic [5:0] addr_counter_i,
   output logic [WORD_W-1:0] word_o,
   output logic word_valid_o,
   output logic word_register_select_o,
   output logic word_rw_o,
   output logic word_t_o,
   output logic [5:0] bit_count_o,
   output logic busy_o
);
   logic rst_m_q;
   logic rst_n_q;
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_m_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_m_q <= 1'b1;
         rst_n_q <= rst_m_q;
      end
   end

   logic [5:0] pins_s;
   // sync flops reset to the idle pin levels, so no false edge follows reset
   lsp_sync #(.WIDTH(6), .RST_VAL(6'h30)) i_lsp_sync (
      .clk_i(clk_i),
      .reset_n_i(rst_n_q),
      .async_i({chip_select_n_i, serial_clk_i, serial_data_io_i,
                register_select_i, read_write_i, test_status_select_i}),
      .sync_o(pins_s)
   );
   logic cs_n_s, sck_s, sdi_s, rsel_s, rw_s, t_s;
   assign {cs_n_s, sck_s, sdi_s, rsel_s, rw_s, t_s} = pins_s;

   logic cs_n_q, cs_n_d, sck_q, sck_d;
   logic [WORD_W-1:0] sh_q, sh_d, out_q, out_d, word_q, word_d;
   logic valid_q, valid_d, rsel_q, rsel_d, rw_q, rw_d, t_q, t_d;
   logic sdo_q, sdo_d, oe_q, oe_d;
   logic busy_q, busy_d;
   logic [5:0] cnt_q, cnt_d;
   logic [9:0] gap_q, gap_d;
   lsp_state_t st_q, st_d;
   logic cs_fall, cs_rise, sck_rise, sck_fall;

   assign cs_fall = cs_n_q && !cs_n_s;
   assign cs_rise = !cs_n_q && cs_n_s;
   assign sck_rise = !sck_q && sck_s;
   assign sck_fall = sck_q && !sck_s;

   always_comb begin
      cs_n_d = cs_n_s;
      sck_d = sck_s;
      st_d = st_q;
      sh_d = sh_q;
      out_d = out_q;
      word_d = word_q;
      valid_d = 1'b0;
      rsel_d = rsel_q;
      rw_d = rw_q;
      t_d = t_q;
      sdo_d = sdo_q;
      oe_d = oe_q;
      cnt_d = cnt_q;
      gap_d = (gap_q != 10'h000) ? gap_q - 10'h001 : gap_q;
      case (st_q)
         LSP_IDLE, LSP_GAP: begin
            oe_d = 1'b0; // see (RL11)
            // a select fall inside the gap is still taken; the gap only shows on busy
            if (st_q == LSP_GAP && gap_q == 10'h000) begin
               st_d = LSP_IDLE;
            end
            if (cs_fall) begin // see (RL1)
               st_d = LSP_SHIFT;
               rsel_d = rsel_s; // see (RL7)
               rw_d = rw_s;
               t_d = t_s;
               cnt_d = 6'h00;
               sh_d = '0;
               // input port frozen here so pin changes cannot tear the read word
               if (rw_s && !rsel_s && t_s) begin
                  out_d = {{(WORD_W - 7){1'b0}}, internal_busy_flag_i, addr_counter_i}; // see (RL10)
               end else if (rw_s && !rsel_s) begin
                  out_d = {{(WORD_W - 8){1'b0}}, input_port_i}; // see (RL9)
               end else begin
                  out_d = read_word_i;
               end
               // line stays low until the first clock fall; the clock is taken to idle high
               sdo_d = 1'b0;
               oe_d = rw_s; // see (RL11)
            end
         end
         LSP_SHIFT: begin
            if (sck_rise) begin
               sh_d = {sh_q[WORD_W-2:0], sdi_s}; // see (RL3) (RL2) (RL5)
               cnt_d = (cnt_q == 6'h3F) ? cnt_q : cnt_q + 6'h01;
            end
            if (sck_fall && rw_q) begin
               sdo_d = out_q[WORD_W-1]; // see (RL6) (RL2)
               out_d = {out_q[WORD_W-2:0], 1'b0};
            end
            if (cs_rise) begin
               word_d = sh_q; // see (RL4)
               valid_d = 1'b1;
               oe_d = 1'b0; // see (RL11)
               st_d = LSP_GAP;
               gap_d = 10'(`LSP_GAP_CYC); // see (RL8)
            end
         end
         default: begin
            st_d = LSP_IDLE;
            oe_d = 1'b0;
         end
      endcase
      // registered so busy_o leaves straight from a flop
      busy_d = (st_d != LSP_IDLE);
   end

   always_ff @(posedge clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         cs_n_q <= 1'b1;
         sck_q <= 1'b1;
         st_q <= LSP_IDLE;
         sh_q <= '0;
         out_q <= '0;
         word_q <= '0;
         valid_q <= 1'b0;
         rsel_q <= 1'b0;
         busy_q <= 1'b0;
         rw_q <= 1'b0;
         t_q <= 1'b0;
         sdo_q <= 1'b0;
         oe_q <= 1'b0;
         cnt_q <= 6'h00;
         gap_q <= 10'h000;
      end else begin
         cs_n_q <= cs_n_d;
         sck_q <= sck_d;
         st_q <= st_d;
         sh_q <= sh_d;
         out_q <= out_d;
         word_q <= word_d;
         valid_q <= valid_d;
         rsel_q <= rsel_d;
         busy_q <= busy_d;
         rw_q <= rw_d;
         t_q <= t_d;
         sdo_q <= sdo_d;
         oe_q <= oe_d;
         cnt_q <= cnt_d;
         gap_q <= gap_d;
      end
   end

   assign serial_data_io_o = sdo_q;
   assign serial_data_io_oe_o = oe_q;
   assign word_o = word_q;
   assign word_valid_o = valid_q;
   assign word_register_select_o = rsel_q;
   assign word_rw_o = rw_q;
   assign word_t_o = t_q;
   assign bit_count_o = cnt_q;
   assign busy_o = busy_q;

   idle_undriven_a: assert property (@(posedge clk_i) disable iff (!rst_n_q) // see (RL11)
      st_q == LSP_IDLE |-> !oe_q) else $error("data line driven while idle");
   shift_in_a: assert property (@(posedge clk_i) disable iff (!rst_n_q) // see (RL3)
      st_q == LSP_SHIFT && sck_rise |=> sh_q[0] == $past(sdi_s))
      else $error("bit not shifted");
   count_up_a: assert property (@(posedge clk_i) disable iff (!rst_n_q) // see (RL3)
      st_q == LSP_SHIFT && sck_rise && cnt_q != 6'h3F |=> cnt_q == $past(cnt_q) + 6'h01)
      else $error("bit count not advanced");
   latch_word_a: assert property (@(posedge clk_i) disable iff (!rst_n_q) // see (RL4)
      st_q == LSP_SHIFT && cs_rise |=> valid_q && word_q == $past(sh_q))
      else $error("word not latched");
   select_start_a: assert property (@(posedge clk_i) disable iff (!rst_n_q) // see (RL1)
      st_q == LSP_IDLE && !cs_fall |=> st_q == LSP_IDLE)
      else $error("left idle without select");
   msb_out_a: assert property (@(posedge clk_i) disable iff (!rst_n_q) // see (RL6)
      st_q == LSP_SHIFT && rw_q && sck_fall |=> sdo_q == $past(out_q[WORD_W-1]))
      else $error("wrong output bit");
   read_drive_a: assert property (@(posedge clk_i) disable iff (!rst_n_q) // see (RL11)
      $rose(st_q == LSP_SHIFT) |-> oe_q == rw_q)
      else $error("drive enable does not follow direction");
   write_quiet_a: assert property (@(posedge clk_i) disable iff (!rst_n_q) // see (RL11)
      st_q == LSP_SHIFT && !rw_q |-> !oe_q) else $error("driven on write");
   port_capture_a: assert property (@(posedge clk_i) disable iff (!rst_n_q) // see (RL9)
      st_q != LSP_SHIFT && cs_fall && rw_s && !rsel_s && !t_s
      |=> out_q[7:0] == $past(input_port_i)) else $error("input port not captured");
   gap_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_q) // see (RL8)
      $rose(st_q == LSP_GAP) |-> busy_o[*8]) else $error("gap too short");
   gap_load_a: assert property (@(posedge clk_i) disable iff (!rst_n_q) // see (RL8)
      $rose(st_q == LSP_GAP) |-> gap_q == 10'(`LSP_GAP_CYC)) else $error("gap not loaded");
   gap_stay_a: assert property (@(posedge clk_i) disable iff (!rst_n_q) // see (RL8)
      st_q == LSP_GAP && gap_q != 10'h000 && !cs_fall |=> st_q == LSP_GAP)
      else $error("gap left early");
   valid_pulse_a: assert property (@(posedge clk_i) disable iff (!rst_n_q) // see (RL4)
      valid_q |=> !valid_q) else $error("valid not a pulse");
   write_c: cover property (@(posedge clk_i) valid_q && !rw_q);
   read_c: cover property (@(posedge clk_i) valid_q && rw_q);
   long_c: cover property (@(posedge clk_i) valid_q && cnt_q > 6'h10);
   status_c: cover property (@(posedge clk_i) valid_q && rw_q && t_q && !rsel_q);
   gap_select_c: cover property (@(posedge clk_i) st_q == LSP_GAP && cs_fall);
endmodule // lsp_port

// file: rtl/lsp_defs.svh
// lsp_defs.svh: constants of the serial host port of the lcd controller.
// assumes inclusion by the package and the port module only.
// Operation
// (RL1) port idle while select high; shifting only once select goes low.
// (RL2) words move msb first, bit fifteen down to bit zero.
// (RL3) while selected, each rising serial clock edge shifts one data bit in.
// (RL4) select rising edge hands the shifted word in parallel to instruction logic.
// (RL5) more than sixteen bits in one selection: the last sixteen count.
// (RL6) read transfers put each next output bit out on falling clock edge.
// (RL7) host settles select levels before select falls and holds them through.
// (RL8) host waits 500 ns plus execution time between select rise and fall.
// (RL9) input port state is captured at select falling edge for the read.
// (RL10) busy flag reported on request; host issues nothing while it reads 1.
// (RL11) data line undriven while select high or transfer is a write.
`ifndef LSP_DEFS_SVH
`define LSP_DEFS_SVH
`define LSP_WORD_W 16
`define LSP_CNT_W 5
`define LSP_GAP_NS 500
`define LSP_CLK_NS 10
`define LSP_GAP_CYC ((`LSP_GAP_NS + `LSP_CLK_NS - 1) / `LSP_CLK_NS)
`define LSP_BUSY_BIT 6
`endif

// file: rtl/lsp_pkg.sv
// lsp_pkg.sv: types of the serial host port.
// assumes lsp_defs.svh on the include path.
`include "lsp_defs.svh"
package lsp_pkg;
   typedef logic [`LSP_WORD_W-1:0] lsp_word_t;
   typedef enum logic [2:0] {
      LSP_IDLE = 3'h1,
      LSP_SHIFT = 3'h2,
      LSP_GAP = 3'h4
   } lsp_state_t;
endpackage

// file: rtl/lsp_sync.sv
// lsp_sync.sv: two flip-flop synchroniser for pin inputs.
// assumes asynchronous inputs and an active-low reset.
`timescale 1ns/10ps
module lsp_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         meta_q <= RST_VAL;
         sync_q <= RST_VAL;
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end
   assign sync_o = sync_q;
endmodule // lsp_sync

// file: tb/lsp_host_model.sv
// lsp_host_model.sv: behavioural microprocessor master of the serial host port.
// assumes the device's data out and enable come back here to resolve the line.
`timescale 1ns/10ps
module lsp_host_model (
   output logic cs_n_o,
   output logic sck_o,
   output logic line_o,
   output logic rsel_o,
   output logic rw_o,
   output logic t_o,
   input wire logic dev_d_i,
   input wire logic dev_oe_i
);
   logic d_q = 1'b0;
   logic drv_q = 1'b0;
   initial begin
      cs_n_o = 1'b1;
      sck_o = 1'b1;
      {t_o, rw_o, rsel_o} = 3'h0;
   end
   // released line shows the inverse of its last value, never a stale copy
   assign line_o = dev_oe_i ? dev_d_i : (drv_q ? d_q : ~d_q);
   task automatic xfer(input logic [2:0] sel, input int n, input logic [31:0] w,
                       output logic [15:0] r);
      #2; // keeps every pin change off the sampling edges of the 10 ns clock
      {t_o, rw_o, rsel_o} = sel;
      drv_q = !sel[1];
      #300 cs_n_o = 1'b0;
      #200;
      for (int i = n - 1; i >= 0; i--) begin
         sck_o = 1'b0;
         d_q = w[i];
         #62.5 sck_o = 1'b1;
         r = {r[14:0], line_o};
         #62.5;
      end
      #200 cs_n_o = 1'b1;
      drv_q = 1'b0;
      #700;
   endtask
endmodule // lsp_host_model

// file: tb/test_lcd_ctrl_serial_host_port.sv
// test_lcd_ctrl_serial_host_port.sv: self-checking bench of the serial host port.
// assumes lsp_pkg, lsp_port and lsp_host_model compiled before it.
`timescale 1ns/10ps
module test_lcd_ctrl_serial_host_port;
   import lsp_pkg::*;
   logic clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic cs_n, sck, line, rsel, rw, t, sdo, oe, valid, wrs, wrw, wt, busy;
   logic bflag = 1'b0;
   logic [7:0] in_port = 8'h00;
   logic [5:0] addr = 6'h00;
   logic [5:0] bits;
   lsp_word_t word, r;
   lsp_word_t rd_word = 16'h0000;
   int fail_count = 0;
   int samples_checked = 0;
   int nval = 0;
   int oe_bad = 0;
   always #5 clk_i = ~clk_i;
   // sampled on the falling edge so a flop output is never read as it launches
   always @(negedge clk_i) begin
      if (valid === 1'b1) nval++;
      if (oe === 1'b1 && rw === 1'b0) oe_bad++;
   end
   lsp_port i_lsp_port (.clk_i(clk_i), .reset_n_i(reset_n_i), .chip_select_n_i(cs_n),
      .serial_clk_i(sck), .serial_data_io_i(line), .serial_data_io_o(sdo),
      .serial_data_io_oe_o(oe), .register_select_i(rsel), .read_write_i(rw),
      .test_status_select_i(t), .input_port_i(in_port), .read_word_i(rd_word),
      .internal_busy_flag_i(bflag), .addr_counter_i(addr), .word_o(word),
      .word_valid_o(valid), .word_register_select_o(wrs), .word_rw_o(wrw), .word_t_o(wt),
      .bit_count_o(bits), .busy_o(busy));
   lsp_host_model i_lsp_host_model (.cs_n_o(cs_n), .sck_o(sck), .line_o(line),
      .rsel_o(rsel), .rw_o(rw), .t_o(t), .dev_d_i(sdo), .dev_oe_i(oe));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic frame(input logic [2:0] sel, input int n, input logic [31:0] w);
      int v;
      v = nval;
      i_lsp_host_model.xfer(sel, n, w, r);
      check(16'(nval - v), 16'h0001);
      check({14'h0, oe, busy}, 16'h0000);
   endtask
   task automatic t_write();
      frame(3'h1, 16, 32'h0000B3C5);
      check(word, 16'hB3C5);
      check({13'h0, wt, wrw, wrs}, 16'h0001);
      check({10'h0, bits}, 16'h0010);
      check(16'(oe_bad), 16'h0000);
   endtask
   task automatic t_long();
      frame(3'h4, 20, 32'h000A5A0F);
      check(word, 16'h5A0F);
      check({13'h0, wt, wrw, wrs}, 16'h0004);
   endtask
   task automatic t_read_port();
      @(posedge clk_i) in_port <= 8'hA5;
      fork
         frame(3'h2, 16, 32'h0);
         begin
            #700;
            @(posedge clk_i) in_port <= 8'h3C;
         end
      join
      check(r & 16'h00FF, 16'h00A5);
   endtask
   task automatic t_read_status();
      @(posedge clk_i) bflag <= 1'b1;
      addr <= 6'h2A;
      frame(3'h6, 16, 32'h0);
      check(r & 16'h007F, 16'h006A);
      @(posedge clk_i) bflag <= 1'b0;
   endtask
   task automatic t_read_word();
      @(posedge clk_i) rd_word <= 16'hC35A;
      frame(3'h3, 16, 32'h0);
      check(r, 16'hC35A);
   endtask
   task automatic wrap_up();
      $display("checks %0d errors %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge clk_i);
      reset_n_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      t_write();
      t_long();
      t_read_port();
      t_read_status();
      t_read_word();
      wrap_up();
   end
   // five frames of about 3.5 us each; generous margin
   initial begin
      #200000;
      fail_count++;
      wrap_up();
   end
endmodule // test_lcd_ctrl_serial_host_port
